// [hdl/scb_pkg.sv]
// Summary of operation
// - cascade output goes low when the counter reaches the active space maximum
// - paging on: two-bit bank choice selects which partition end is the maximum
// - banks 00,01,10,11 cover 00000-3FFFF, 40000-7FFFF, 80000-BFFFF, C0000-FFFFF
// - paging off: bank choice ignored, one space from zero to the top address
// - after the maximum, cascade stays low while selected and output enabled
// - then cascade follows chip select until enable drops, then high until reread
// - in programming mode the device-select input acts as chip select
// - ready pin driven low during power-up reset, released when it completes
// - mode select stays high for reads; low enters two-wire programming mode
// - low reset/enable clears the address counter and floats the data pin
// - chip select high after reset keeps counter halted and data floating
// - enable high while selected starts the counter and the data driver
// - with mode select high, every later low on reset/enable clears the counter and floats data
// - after the last bit and cascade low, the data pin floats
// - address counter held clear until the power-up timer, started by a rst pulse, completes
// - a chained device drives data once its chip select is pulled low
// - selected and enabled, each clock advances; deselected, counters halt in standby
// - in programming mode paging enable and bank choice are ignored
// - in standby the data output floats whatever the enable level
package scb_pkg;

  // ---------------------------------------------------------------
  // address space
  // ---------------------------------------------------------------
  localparam int          ADDR_W     = 20;
  localparam int          BANK_W     = 2;
  localparam int          WORD_W_DEF = 16;
  localparam logic [19:0] FULL_FIRST = 20'h00000;
  localparam logic [19:0] FULL_LAST  = 20'hFFFFF;
  localparam logic [19:0] BANK_FIRST [4] = '{20'h00000, 20'h40000, 20'h80000, 20'hC0000};
  localparam logic [19:0] BANK_LAST  [4] = '{20'h3FFFF, 20'h7FFFF, 20'hBFFFF, 20'hFFFFF};

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int POR_TIME_NS   = 1000;
  localparam int POR_CYCLES    = (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic READY_OE_N_RST = 1'b0;
  localparam logic READY_OUT_VAL  = 1'b0;

  // ---------------------------------------------------------------
  // link state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SCB_CLEAR = 4'b0001,
    SCB_RUN   = 4'b0010,
    SCB_DONE  = 4'b0100,
    SCB_PROG  = 4'b1000
  } scb_state_t;

  typedef struct packed {
    logic              cs_n;
    logic              reset_oe_n;
    logic              mode_n;
    logic              dev_sel;
    logic              page_en;
    logic [BANK_W-1:0] bank;
  } scb_pins_t;

  // first address of the active space
  function automatic logic [ADDR_W-1:0] space_first(input logic page_en, input logic [BANK_W-1:0] bank);
    return page_en ? BANK_FIRST[bank] : FULL_FIRST;
  endfunction

  // last address of the active space
  function automatic logic [ADDR_W-1:0] space_last(input logic page_en, input logic [BANK_W-1:0] bank);
    return page_en ? BANK_LAST[bank] : FULL_LAST;
  endfunction

endpackage

// [hdl/scb_sync2.sv]
`timescale 1ns/1ps
module scb_sync2 #(
  parameter int W = 1
) (
  input  logic         clk,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ---------------------------------------------------------------
  // two-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    meta_q <= d;
    q      <= meta_q;
  end

endmodule // scb_sync2

// [hdl/scb_por.sv]
`timescale 1ns/1ps
module scb_por #(
  parameter int CYCLES = 250
) (
  input  logic core_clk,
  input  logic rst,
  output logic por_done
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_q;

  // ---------------------------------------------------------------
  // power-up reset timer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_q    <= '0;
      por_done <= 1'b0;
    end
    else if (cnt_q == CNT_W'(CYCLES))
    begin
      por_done <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

endmodule // scb_por

// [hdl/scb_readout.sv]
`timescale 1ns/1ps
module scb_readout
  import scb_pkg::*;
#(
  parameter int WORD_W     = scb_pkg::WORD_W_DEF,
  parameter int POR_CYCLES = scb_pkg::POR_CYCLES
) (
  input  logic                      core_clk,
  input  logic                      rst,
  input  logic                      serial_shift_clock,
  input  logic                      chip_select_n,
  input  logic                      reset_oe_n,
  input  logic                      program_mode_select_n,
  input  logic                      program_device_select,
  input  logic                      page_enable,
  input  logic [scb_pkg::BANK_W-1:0] bank_choice,
  input  logic [WORD_W-1:0]         rd_word,
  output logic [scb_pkg::ADDR_W-1:0] rd_addr,
  output logic                      data_out,
  output logic                      data_oe_n,
  output logic                      cascade_out_n,
  output logic                      ready_out,
  output logic                      ready_oe_n,
  output logic                      program_select,
  output logic                      program_mode,
  output logic                      standby
);

  import scb_pkg::*;

  localparam int BIT_W = (WORD_W > 1) ? $clog2(WORD_W) : 1;
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WORD_W - 1);
  localparam logic [BIT_W-1:0] BIT_ONE  = BIT_W'(1);
  localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);

  // ---------------------------------------------------------------
  // core domain: power-up reset and ready pin
  // ---------------------------------------------------------------
  logic por_done;

  scb_por #(
    .CYCLES   (POR_CYCLES)
  ) u_por (
    .core_clk (core_clk),
    .rst      (rst),
    .por_done (por_done)
  );

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ready_oe_n <= READY_OE_N_RST;
    end
    else
    begin
      ready_oe_n <= por_done;
    end
  end

  always_ff @(posedge core_clk)
  begin
    ready_out <= READY_OUT_VAL;
  end

  // ---------------------------------------------------------------
  // link domain: input synchronisers
  // ---------------------------------------------------------------
  scb_pins_t pins_raw;
  scb_pins_t pins_s;
  logic      por_done_s;

  assign pins_raw.cs_n       = chip_select_n;
  assign pins_raw.reset_oe_n = reset_oe_n;
  assign pins_raw.mode_n     = program_mode_select_n;
  assign pins_raw.dev_sel    = program_device_select;
  assign pins_raw.page_en    = page_enable;
  assign pins_raw.bank       = bank_choice;

  scb_sync2 #(
    .W   ($bits(scb_pins_t))
  ) u_sync_pins (
    .clk (serial_shift_clock),
    .d   (pins_raw),
    .q   (pins_s)
  );

  scb_sync2 #(
    .W   (1)
  ) u_sync_por (
    .clk (serial_shift_clock),
    .d   (por_done),
    .q   (por_done_s)
  );

  // ---------------------------------------------------------------
  // link domain: mode decode
  // ---------------------------------------------------------------
  logic              cfg_mode;
  logic              out_en;
  logic              selected;
  logic              page_en_eff;
  logic [ADDR_W-1:0] first_addr;
  logic [ADDR_W-1:0] last_addr;

  assign cfg_mode    = pins_s.mode_n;
  assign out_en      = pins_s.reset_oe_n;
  assign selected    = ~pins_s.cs_n;
  assign page_en_eff = cfg_mode & pins_s.page_en;
  assign first_addr  = space_first(page_en_eff, pins_s.bank);
  assign last_addr   = space_last(page_en_eff, pins_s.bank);

  // ---------------------------------------------------------------
  // link domain: read-out state
  // ---------------------------------------------------------------
  scb_state_t        state_q;
  scb_state_t        state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [BIT_W-1:0]  bit_q;
  logic              step;
  logic              at_end;

  assign step   = (state_q == SCB_RUN) & selected & out_en;
  assign at_end = (addr_q == last_addr) & (bit_q == BIT_LAST);

  always_comb
  begin
    state_d = state_q;
    if (!por_done_s)
    begin
      state_d = SCB_CLEAR;
    end
    else if (!cfg_mode)
    begin
      state_d = SCB_PROG;
    end
    else
    begin
      case (state_q)
        SCB_CLEAR:
        begin
          if (out_en)
          begin
            state_d = SCB_RUN;
          end
        end
        SCB_RUN:
        begin
          if (!out_en)
          begin
            state_d = SCB_CLEAR;
          end
          else if (step && at_end)
          begin
            state_d = SCB_DONE;
          end
        end
        SCB_DONE:
        begin
          if (!out_en)
          begin
            state_d = SCB_CLEAR;
          end
        end
        SCB_PROG:
        begin
          state_d = SCB_CLEAR;
        end
        default:
        begin
          state_d = SCB_CLEAR;
        end
      endcase
    end
  end

  always_ff @(posedge serial_shift_clock)
  begin
    state_q <= state_d;
  end

  // ---------------------------------------------------------------
  // link domain: address and bit counters
  // ---------------------------------------------------------------
  always_ff @(posedge serial_shift_clock)
  begin
    if (!por_done_s)
    begin
      addr_q <= FULL_FIRST;
      bit_q  <= '0;
    end
    else if (cfg_mode && !out_en)
    begin
      addr_q <= first_addr;
      bit_q  <= '0;
    end
    else if (step && !at_end)
    begin
      if (bit_q == BIT_LAST)
      begin
        bit_q  <= '0;
        addr_q <= addr_q + ADDR_ONE;
      end
      else
      begin
        bit_q <= bit_q + BIT_ONE;
      end
    end
  end

  always_ff @(posedge serial_shift_clock)
  begin
    rd_addr <= addr_q;
  end

  // ---------------------------------------------------------------
  // link domain: data pin
  // ---------------------------------------------------------------
  logic [BIT_W-1:0] bit_l_q;
  logic             step_q;

  always_ff @(posedge serial_shift_clock)
  begin
    bit_l_q <= bit_q;
  end

  // driver follows the bit pipeline so the last bit is not cut
  always_ff @(posedge serial_shift_clock)
  begin
    step_q <= step;
  end

  always_ff @(posedge serial_shift_clock)
  begin
    data_out <= rd_word[bit_l_q];
  end

  always_ff @(posedge serial_shift_clock)
  begin
    if (step_q && cfg_mode && selected && out_en)
    begin
      data_oe_n <= 1'b0;
    end
    else
    begin
      data_oe_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // link domain: cascade output
  // ---------------------------------------------------------------
  always_ff @(posedge serial_shift_clock)
  begin
    if (state_q == SCB_DONE && !step_q && cfg_mode && out_en)
    begin
      cascade_out_n <= pins_s.cs_n;
    end
    else
    begin
      cascade_out_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // link domain: programming mode and standby flags
  // ---------------------------------------------------------------
  always_ff @(posedge serial_shift_clock)
  begin
    program_mode   <= ~cfg_mode;
    program_select <= ~cfg_mode & pins_s.dev_sel;
  end

  always_ff @(posedge serial_shift_clock)
  begin
    standby <= cfg_mode & ~selected;
  end

endmodule // scb_readout

// [testbench/scb_fpga_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------
// far side: serial clock and stored words
// ---------------------------------------------
module scb_fpga_model (
  output logic                      serial_shift_clock,
  input  logic [scb_pkg::ADDR_W-1:0] rd_addr,
  output logic [15:0]               rd_word
);
  import scb_pkg::*;
  initial
  begin
    serial_shift_clock = 1'b0;
    #13;
    forever #40 serial_shift_clock = ~serial_shift_clock;
  end
  assign rd_word = rd_addr[15:0] ^ 16'hA5C3;
endmodule // scb_fpga_model

// [testbench/scb_readout_asserts.sv]
`timescale 1ns/1ps
// ---------------------------------------------
// port checks
// ---------------------------------------------
module scb_readout_asserts #(
  parameter int POR_CYCLES = 250
) (
  input logic                      core_clk,
  input logic                      rst,
  input logic                      serial_shift_clock,
  input logic                      chip_select_n,
  input logic                      reset_oe_n,
  input logic                      program_mode_select_n,
  input logic                      program_device_select,
  input logic [scb_pkg::ADDR_W-1:0] rd_addr,
  input logic                      data_oe_n,
  input logic                      cascade_out_n,
  input logic                      ready_out,
  input logic                      ready_oe_n,
  input logic                      program_select,
  input logic                      program_mode,
  input logic                      standby
);
  import scb_pkg::*;
  localparam int POR_HI = POR_CYCLES + 4;
  logic [2:0] live_q = 3'h0;
  wire        live   = (live_q == 3'h7);
  always_ff @(posedge serial_shift_clock)
    live_q <= !ready_oe_n ? 3'h0 : (live ? live_q : live_q + 3'h1);

  chk_ready_por: assert property (@(posedge core_clk) disable iff (rst)
    $fell(rst) |-> (!ready_oe_n && !ready_out)[*4] ##[1:POR_HI] ready_oe_n)
    else $error("ready pin not released after power-up reset");
  chk_clear_float: assert property (@(posedge serial_shift_clock) disable iff (!live)
    (!reset_oe_n)[*4] |-> data_oe_n && cascade_out_n)
    else $error("data driven or cascade low while cleared");
  chk_standby_float: assert property (@(posedge serial_shift_clock) disable iff (!live)
    (chip_select_n && program_mode_select_n)[*4] |-> standby && data_oe_n)
    else $error("deselected device not in standby");
  chk_prog_mode: assert property (@(posedge serial_shift_clock) disable iff (!live)
    (!program_mode_select_n)[*4] |-> program_mode && data_oe_n)
    else $error("programming mode not entered");
  chk_prog_select: assert property (@(posedge serial_shift_clock) disable iff (!live)
    (!program_mode_select_n && program_device_select)[*4] |-> program_select)
    else $error("device select ignored in programming mode");
  chk_addr_step: assert property (@(posedge serial_shift_clock) disable iff (!live)
    !data_oe_n && $past(!data_oe_n) && (rd_addr != $past(rd_addr)) |-> rd_addr == $past(rd_addr) + 1'b1)
    else $error("address skipped while streaming");
  chk_addr_hold: assert property (@(posedge serial_shift_clock) disable iff (!live)
    (chip_select_n && reset_oe_n)[*4] |=> $stable(rd_addr))
    else $error("address moved while deselected");
  chk_cascade_end: assert property (@(posedge serial_shift_clock) disable iff (!live)
    $fell(cascade_out_n) |-> data_oe_n && (rd_addr[17:0] == 18'h3FFFF))
    else $error("cascade low away from space end");
  chk_cascade_hold: assert property (@(posedge serial_shift_clock) disable iff (!live)
    (!chip_select_n && reset_oe_n && program_mode_select_n)[*4] ##0 !cascade_out_n |=> !cascade_out_n)
    else $error("cascade released while selected");
endmodule // scb_readout_asserts

bind scb_readout scb_readout_asserts #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .core_clk(core_clk), .rst(rst), .serial_shift_clock(serial_shift_clock),
  .chip_select_n(chip_select_n), .reset_oe_n(reset_oe_n),
  .program_mode_select_n(program_mode_select_n), .program_device_select(program_device_select),
  .rd_addr(rd_addr), .data_oe_n(data_oe_n), .cascade_out_n(cascade_out_n), .ready_out(ready_out),
  .ready_oe_n(ready_oe_n), .program_select(program_select), .program_mode(program_mode), .standby(standby));

// [testbench/scb_readout_test.sv]
`timescale 1ns/1ps
// ---------------------------------------------
// read-out bench
// ---------------------------------------------
module scb_readout_test;
  import scb_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        lclk;
  scb_pins_t   pins;
  logic [15:0] rd_word;
  logic [19:0] rd_addr;
  logic [19:0] addr;
  logic [31:0] bits;
  logic        data_out, data_oe_n, cascade_out_n, ready_out, ready_oe_n;
  logic        program_select, program_mode, standby;
  int          n_mismatch;
  int          n_checks;

  scb_fpga_model u_fpga (.serial_shift_clock(lclk), .rd_addr(rd_addr), .rd_word(rd_word));
  scb_readout #(.WORD_W(16), .POR_CYCLES(4)) uut (
    .core_clk(core_clk), .rst(rst), .serial_shift_clock(lclk), .chip_select_n(pins.cs_n),
    .reset_oe_n(pins.reset_oe_n), .program_mode_select_n(pins.mode_n),
    .program_device_select(pins.dev_sel), .page_enable(pins.page_en), .bank_choice(pins.bank),
    .rd_word(rd_word), .rd_addr(rd_addr), .data_out(data_out), .data_oe_n(data_oe_n),
    .cascade_out_n(cascade_out_n), .ready_out(ready_out), .ready_oe_n(ready_oe_n),
    .program_select(program_select), .program_mode(program_mode), .standby(standby));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic drive(input logic cs, oe, mode, sel, pe, input logic [1:0] b);
    @(posedge core_clk);
    pins <= {cs, oe, mode, sel, pe, b};
  endtask

  task automatic lwait(input int n);
    repeat (n) @(negedge lclk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clear(input logic cs, pe, input logic [1:0] b, input logic [19:0] first);
    drive(cs, 1'b0, 1'b1, 1'b0, pe, b);
    lwait(5);
    check({12'h0, rd_addr}, {12'h0, first});
    check({31'h0, data_oe_n}, 32'h1);
    check({31'h0, cascade_out_n}, 32'h1);
    drive(cs, 1'b1, 1'b1, 1'b0, pe, b);
    lwait(4);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #200us;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    rst = 1'b1;
    pins = 7'b1110000;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check({31'h0, ready_oe_n}, 32'h0);
    repeat (8) @(negedge core_clk);
    check({30'h0, ready_oe_n, ready_out}, 32'h2);
    lwait(6);
    check({12'h0, rd_addr}, 32'h0);
    check({30'h0, standby, data_oe_n}, 32'h3);
    $display("test power_up done");
    for (int i = 0; i < 8; i++)
      clear(1'b1, i[2], i[1:0], i[2] ? {i[1:0], 18'h0} : 20'h0);
    $display("test paging done");
    clear(1'b1, 1'b1, 2'h2, 20'h80000);
    drive(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'h2);
    for (int k = 0; k < 20 && data_oe_n !== 1'b0; k++)
      lwait(1);
    check({31'h0, data_oe_n}, 32'h0);
    for (int k = 0; k < 32; k++)
    begin
      bits[k] = data_out;
      lwait(1);
    end
    check(bits, {16'hA5C2, 16'hA5C3});
    drive(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'h2);
    lwait(4);
    check({30'h0, standby, data_oe_n}, 32'h3);
    addr = rd_addr;
    lwait(8);
    check({12'h0, rd_addr}, {12'h0, addr});
    clear(1'b1, 1'b1, 2'h2, 20'h80000);
    $display("test stream done");
    drive(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h3);
    lwait(4);
    check({29'h0, program_mode, program_select, data_oe_n}, 32'h7);
    drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h3);
    lwait(6);
    check({30'h0, program_select, data_oe_n}, 32'h1);
    check({12'h0, rd_addr}, 32'h80000);
    drive(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
    lwait(4);
    check({31'h0, program_mode}, 32'h0);
    $display("test program_mode done");
    stop_test();
  end
endmodule // scb_readout_test
